// >>> hdl/usr_top.sv
// clocked half-duplex serial port: master/slave reception, slave
// transmission, buffer handover, flags and wake-up; AXI4-Lite registers.
// assumes pins arrive asynchronous to I_REF_CLK; I_SLEEP is core logic.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module usr_top (
	input wire logic I_REF_CLK, // core clock, 200 MHz
	input wire logic I_SYS_RST, // synchronous reset, high
	input wire logic [5:0] I_AWADDR, // write address
	input wire logic I_AWVALID, // write address valid
	output logic O_AWREADY, // write address ready
	input wire logic [31:0] I_WDATA, // write data
	input wire logic [3:0] I_WSTRB, // write byte strobes
	input wire logic I_WVALID, // write data valid
	output logic O_WREADY, // write data ready
	output logic [1:0] O_BRESP, // write response
	output logic O_BVALID, // write response valid
	input wire logic I_BREADY, // write response ready
	input wire logic [5:0] I_ARADDR, // read address
	input wire logic I_ARVALID, // read address valid
	output logic O_ARREADY, // read address ready
	output logic [31:0] O_RDATA, // read data
	output logic [1:0] O_RRESP, // read response
	output logic O_RVALID, // read data valid
	input wire logic I_RREADY, // read data ready
	input wire logic I_CLOCK_PIN, // clock pin level in
	output logic O_CLOCK_PIN, // clock pin level out
	output logic O_CLOCK_PIN_OE, // clock pin driven
	input wire logic I_DATA_PIN, // data pin level in
	output logic O_DATA_PIN, // data pin level out
	output logic O_DATA_PIN_OE, // data pin driven
	input wire logic I_SLEEP, // core in power-managed mode
	output logic O_INT, // interrupt to core
	output logic O_WAKE // wake request from sleep
);

	// ====================================================================
	// state
	logic awrdy, wrdy, bvalid, arrdy, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [5:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	logic [7:0] interrupt_control_core, peripheral_enables_one, peripheral_priority_one, baud_divisor, transmit_data_buffer;
	logic serial_port_enable, rx9, single_word_receive_enable, continuous_receive_enable, adden;
	logic clock_source_select, tx9, transmit_enable_bit, sync, brgh, transmit_ninth_data;
	logic receive_int_flag, transmit_int_flag, overrun_error_flag, tx_full;
	usr_pkg::usr_word_s rx_buf;
	usr_pkg::usr_state_e state;
	logic is_tx;
	logic [3:0] cnt;
	logic [8:0] sh;
	logic [7:0] div_cnt;
	logic ck_lvl, ck_oe, dt_o, dt_oe;
	logic [2:0] ck_s, dt_s;
	logic ck_f, ck_prev, dt_f;
	logic int_q, wake_q;

	// ====================================================================
	// combinational terms
	logic wr_go, wr_en, wr_map, rd_hs, rd_receive_data_buffer;
	logic wr_receive_status_control, wr_transmit_data_buffer, continuous_receive_enable_clr;
	logic port_on, master, rx_en, tx_load, abort;
	logic tick, m_fall, s_fall, fall_ev, word_end, rx_done;
	logic [3:0] nbits;
	logic [31:0] rd_mux;
	logic rd_map;
	usr_pkg::usr_word_s rx_word;
	logic pend;

	// bus write fires once both halves are held and no answer pends
	assign wr_go = !awrdy && !wrdy && !bvalid;
	assign wr_en = wr_go && w_lane0;
	assign wr_receive_status_control = wr_en && (aw_addr == usr_pkg::OFF_RECEIVE_STATUS_CONTROL);
	assign wr_transmit_data_buffer = wr_en && (aw_addr == usr_pkg::OFF_TRANSMIT_DATA_BUFFER);
	assign continuous_receive_enable_clr = wr_receive_status_control && continuous_receive_enable && !w_byte[usr_pkg::B_CONTINUOUS_RECEIVE_ENABLE];
	assign rd_hs = I_ARVALID && arrdy;
	assign rd_receive_data_buffer = rd_hs && (I_ARADDR == usr_pkg::OFF_RECEIVE_DATA_BUFFER);

	// mode decode; slave looks only at the continuous enable
	assign port_on = serial_port_enable && sync;
	assign master = clock_source_select;
	assign rx_en = master ? (single_word_receive_enable || continuous_receive_enable) : continuous_receive_enable;
	assign tx_load = (state == usr_pkg::USR_IDLE) && port_on && !rx_en
		&& transmit_enable_bit && tx_full && !wr_transmit_data_buffer;
	assign abort = !port_on || (!is_tx && !rx_en);
	assign nbits = (is_tx ? tx9 : rx9) ? usr_pkg::NBITS9 : usr_pkg::NBITS8;

	// shift clock events; master clock halts while the core sleeps
	assign tick = (state == usr_pkg::USR_SHIFT) && master && !I_SLEEP
		&& (div_cnt == baud_divisor);
	assign m_fall = tick && ck_lvl;
	assign s_fall = ck_prev && !ck_f;
	assign fall_ev = master ? m_fall : s_fall;
	assign word_end = (state == usr_pkg::USR_SHIFT) && !abort && fall_ev
		&& (cnt == nbits - 4'h1);
	assign rx_done = word_end && !is_tx;

	// assemble the finished word including the bit sampled now
	always_comb begin
		if (rx9) begin
			rx_word.ninth = dt_f;
			rx_word.data = sh[8:1];
		end else begin
			rx_word.ninth = 1'b0;
			rx_word.data = {dt_f, sh[8:2]};
		end
	end

	// ====================================================================
	// pin synchronisers: a change counts when stages two and three agree
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			ck_s <= 3'h0;
			dt_s <= 3'h0;
			ck_f <= 1'b0;
			dt_f <= 1'b0;
			ck_prev <= 1'b0;
		end else begin
			ck_s <= {ck_s[1:0], I_CLOCK_PIN};
			dt_s <= {dt_s[1:0], I_DATA_PIN};
			if (ck_s[1] == ck_s[2])
				ck_f <= ck_s[2];
			if (dt_s[1] == dt_s[2])
				dt_f <= dt_s[2];
			ck_prev <= ck_f;
		end
	end

	// ====================================================================
	// AXI4-Lite write channels: address and data taken in either order
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			awrdy <= 1'b1;
			wrdy <= 1'b1;
			bvalid <= 1'b0;
			bresp <= usr_pkg::RESP_OKAY;
			aw_addr <= 6'h00;
			w_byte <= usr_pkg::RST_BYTE;
			w_lane0 <= 1'b0;
		end else begin
			if (I_AWVALID && awrdy) begin
				awrdy <= 1'b0;
				aw_addr <= I_AWADDR;
			end else if (bvalid && I_BREADY)
				awrdy <= 1'b1;
			if (I_WVALID && wrdy) begin
				wrdy <= 1'b0;
				w_byte <= I_WDATA[7:0];
				w_lane0 <= I_WSTRB[0];
			end else if (bvalid && I_BREADY)
				wrdy <= 1'b1;
			if (wr_go) begin
				bvalid <= 1'b1;
				bresp <= wr_map ? usr_pkg::RESP_OKAY : usr_pkg::RESP_SLVERR;
			end else if (bvalid && I_BREADY)
				bvalid <= 1'b0;
		end
	end

	// unmapped offsets answer with a slave error
	always_comb begin
		unique case (aw_addr)
			usr_pkg::OFF_INTERRUPT_CONTROL_CORE, usr_pkg::OFF_PERIPHERAL_FLAGS_ONE, usr_pkg::OFF_PERIPHERAL_ENABLES_ONE,
			usr_pkg::OFF_PERIPHERAL_PRIORITY_ONE, usr_pkg::OFF_RECEIVE_STATUS_CONTROL, usr_pkg::OFF_RECEIVE_DATA_BUFFER,
			usr_pkg::OFF_TRANSMIT_STATUS_CONTROL, usr_pkg::OFF_BAUD_DIVISOR, usr_pkg::OFF_TRANSMIT_DATA_BUFFER:
				wr_map = 1'b1;
			default: wr_map = 1'b0;
		endcase
	end

	// ====================================================================
	// read decode; flags shown straight from their flops
	always_comb begin
		rd_map = 1'b1;
		rd_mux = usr_pkg::RD_ZERO;
		unique case (I_ARADDR)
			usr_pkg::OFF_INTERRUPT_CONTROL_CORE: rd_mux[7:0] = interrupt_control_core;
			usr_pkg::OFF_PERIPHERAL_FLAGS_ONE: begin
				rd_mux[usr_pkg::B_RECEIVE_INT_FLAG] = receive_int_flag;
				rd_mux[usr_pkg::B_TRANSMIT_INT_FLAG] = transmit_int_flag;
			end
			usr_pkg::OFF_PERIPHERAL_ENABLES_ONE: rd_mux[7:0] = peripheral_enables_one;
			usr_pkg::OFF_PERIPHERAL_PRIORITY_ONE: rd_mux[7:0] = peripheral_priority_one;
			usr_pkg::OFF_RECEIVE_STATUS_CONTROL: begin
				rd_mux[7:0] = {serial_port_enable, rx9, single_word_receive_enable, continuous_receive_enable, adden, 1'b0, overrun_error_flag,
					rx_buf.ninth};
			end
			usr_pkg::OFF_RECEIVE_DATA_BUFFER: rd_mux[7:0] = rx_buf.data;
			usr_pkg::OFF_TRANSMIT_STATUS_CONTROL: begin
				rd_mux[7:0] = {clock_source_select, tx9, transmit_enable_bit, sync, 1'b0, brgh,
					!(state == usr_pkg::USR_SHIFT && is_tx), transmit_ninth_data};
			end
			usr_pkg::OFF_BAUD_DIVISOR: rd_mux[7:0] = baud_divisor;
			usr_pkg::OFF_TRANSMIT_DATA_BUFFER: rd_mux = usr_pkg::RD_ZERO;
			default: rd_map = 1'b0;
		endcase
	end

	// read channel: one read at a time, data held until taken
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			arrdy <= 1'b1;
			rvalid <= 1'b0;
			rdata <= usr_pkg::RD_ZERO;
			rresp <= usr_pkg::RESP_OKAY;
		end else if (rd_hs) begin
			arrdy <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= rd_map ? usr_pkg::RESP_OKAY : usr_pkg::RESP_SLVERR;
		end else if (rvalid && I_RREADY) begin
			rvalid <= 1'b0;
			arrdy <= 1'b1;
		end
	end

	// ====================================================================
	// software registers; hardware drops single-word enable after a master word when continuous is off
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			interrupt_control_core <= usr_pkg::RST_BYTE;
			peripheral_enables_one <= usr_pkg::RST_BYTE;
			peripheral_priority_one <= usr_pkg::RST_PERIPHERAL_PRIORITY_ONE;
			baud_divisor <= usr_pkg::RST_BYTE;
			{serial_port_enable, rx9, single_word_receive_enable, continuous_receive_enable, adden} <= 5'h00;
			{clock_source_select, tx9, transmit_enable_bit, sync, brgh, transmit_ninth_data} <= 6'h00;
		end else begin
			if (wr_en && aw_addr == usr_pkg::OFF_INTERRUPT_CONTROL_CORE)
				interrupt_control_core <= w_byte;
			if (wr_en && aw_addr == usr_pkg::OFF_PERIPHERAL_ENABLES_ONE)
				peripheral_enables_one <= w_byte;
			if (wr_en && aw_addr == usr_pkg::OFF_PERIPHERAL_PRIORITY_ONE)
				peripheral_priority_one <= w_byte;
			if (wr_en && aw_addr == usr_pkg::OFF_BAUD_DIVISOR)
				baud_divisor <= w_byte;
			if (wr_receive_status_control) begin
				serial_port_enable <= w_byte[usr_pkg::B_SERIAL_PORT_ENABLE];
				rx9 <= w_byte[usr_pkg::B_RX9];
				single_word_receive_enable <= w_byte[usr_pkg::B_SINGLE_WORD_RECEIVE_ENABLE];
				continuous_receive_enable <= w_byte[usr_pkg::B_CONTINUOUS_RECEIVE_ENABLE];
				adden <= w_byte[usr_pkg::B_ADDEN];
			end else if (rx_done && master && !continuous_receive_enable)
				single_word_receive_enable <= 1'b0;
			if (wr_en && aw_addr == usr_pkg::OFF_TRANSMIT_STATUS_CONTROL) begin
				clock_source_select <= w_byte[usr_pkg::B_CLOCK_SOURCE_SELECT];
				tx9 <= w_byte[usr_pkg::B_TX9];
				transmit_enable_bit <= w_byte[usr_pkg::B_TRANSMIT_ENABLE_BIT];
				sync <= w_byte[usr_pkg::B_SYNC];
				brgh <= w_byte[usr_pkg::B_BRGH];
				transmit_ninth_data <= w_byte[usr_pkg::B_TRANSMIT_NINTH_DATA];
			end
		end
	end

	// ====================================================================
	// transmit buffer and its flag; flag rises only at handover
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			transmit_data_buffer <= usr_pkg::RST_BYTE;
			tx_full <= 1'b0;
			transmit_int_flag <= 1'b0;
		end else if (wr_transmit_data_buffer) begin
			transmit_data_buffer <= w_byte;
			tx_full <= 1'b1;
			transmit_int_flag <= 1'b0;
		end else if (tx_load) begin
			tx_full <= 1'b0;
			transmit_int_flag <= 1'b1;
		end
	end

	// ====================================================================
	// receive buffer, flag and overrun; a read racing a new word loses
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			rx_buf <= '0;
			receive_int_flag <= 1'b0;
			overrun_error_flag <= 1'b0;
		end else begin
			if (rx_done && (!receive_int_flag || rd_receive_data_buffer)) begin
				rx_buf <= rx_word;
				receive_int_flag <= 1'b1;
			end else if (rd_receive_data_buffer)
				receive_int_flag <= 1'b0;
			if (rx_done && receive_int_flag && !rd_receive_data_buffer)
				overrun_error_flag <= 1'b1; // word dropped, buffer kept
			else if (continuous_receive_enable_clr)
				overrun_error_flag <= 1'b0;
		end
	end

	// ====================================================================
	// shift engine; first transmit bit driven at load, each later bit moves on a falling shift-clock edge
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			state <= usr_pkg::USR_IDLE;
			is_tx <= 1'b0;
			cnt <= 4'h0;
			sh <= 9'h000;
			dt_o <= 1'b0;
		end else begin
			unique case (state)
				usr_pkg::USR_IDLE: begin
					cnt <= 4'h0;
					if (port_on && rx_en) begin
						state <= usr_pkg::USR_SHIFT;
						is_tx <= 1'b0;
					end else if (tx_load) begin
						state <= usr_pkg::USR_SHIFT;
						is_tx <= 1'b1;
						sh <= {transmit_ninth_data, transmit_data_buffer};
						dt_o <= transmit_data_buffer[0];
					end
				end
				usr_pkg::USR_SHIFT: begin
					if (abort)
						state <= usr_pkg::USR_IDLE;
					else if (fall_ev) begin
						cnt <= cnt + 4'h1;
						if (is_tx) begin
							sh <= {1'b0, sh[8:1]};
							dt_o <= sh[1];
						end else
							sh <= {dt_f, sh[8:1]};
						if (word_end)
							state <= usr_pkg::USR_IDLE;
					end
				end
			endcase
		end
	end

	// ====================================================================
	// master clock divider; clock rests low between words
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			div_cnt <= 8'h00;
			ck_lvl <= 1'b0;
		end else if (state != usr_pkg::USR_SHIFT || !master) begin
			div_cnt <= 8'h00;
			ck_lvl <= 1'b0;
		end else if (tick) begin
			div_cnt <= 8'h00;
			ck_lvl <= !ck_lvl;
		end else if (!I_SLEEP)
			div_cnt <= div_cnt + 8'h01;
	end

	// pin drivers: clock only while shifting, data only while sending
	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			ck_oe <= 1'b0;
			dt_oe <= 1'b0;
		end else begin
			ck_oe <= (state == usr_pkg::USR_SHIFT) && master;
			dt_oe <= (state == usr_pkg::USR_SHIFT) && is_tx;
		end
	end

	// ====================================================================
	// interrupt and wake; wake ignores the core enables
	assign pend = (receive_int_flag && peripheral_enables_one[usr_pkg::B_RECEIVE_INT_FLAG])
		|| (transmit_int_flag && peripheral_enables_one[usr_pkg::B_TRANSMIT_INT_FLAG]);

	always_ff @(posedge I_REF_CLK) begin
		if (I_SYS_RST) begin
			int_q <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			int_q <= pend && interrupt_control_core[usr_pkg::B_GIE]
				&& interrupt_control_core[usr_pkg::B_PERIPHERAL_INT_ENABLE];
			wake_q <= pend && I_SLEEP;
		end
	end

	assign O_AWREADY = awrdy;
	assign O_WREADY = wrdy;
	assign O_BVALID = bvalid;
	assign O_BRESP = bresp;
	assign O_ARREADY = arrdy;
	assign O_RVALID = rvalid;
	assign O_RDATA = rdata;
	assign O_RRESP = rresp;
	assign O_CLOCK_PIN = ck_lvl;
	assign O_CLOCK_PIN_OE = ck_oe;
	assign O_DATA_PIN = dt_o;
	assign O_DATA_PIN_OE = dt_oe;
	assign O_INT = int_q;
	assign O_WAKE = wake_q;

	// ====================================================================
	// checks
	default clocking dc @(posedge I_REF_CLK); endclocking
	default disable iff (I_SYS_RST);

	a_int_gating: assert property (
		O_INT |-> $past(interrupt_control_core[usr_pkg::B_GIE] && interrupt_control_core[usr_pkg::B_PERIPHERAL_INT_ENABLE]))
		else $error("interrupt without core enables");
	a_receive_int_flag_set: assert property (rx_done |=> receive_int_flag)
		else $error("receive flag not set after word");
	a_single_word_receive_enable_drop: assert property (
		(rx_done && master && !continuous_receive_enable && !wr_receive_status_control) |=> !single_word_receive_enable)
		else $error("single-word enable not cleared");
	a_err_clear: assert property (
		(continuous_receive_enable_clr && !rx_done) |=> !overrun_error_flag)
		else $error("overrun flag survived enable clear");
	a_transmit_int_flag_load: assert property (
		tx_load |=> transmit_int_flag && !tx_full ##0 state == usr_pkg::USR_SHIFT)
		else $error("transmit handover without flag");
	a_ninth_latch: assert property (
		(rx_done && rx9 && !receive_int_flag) |=> rx_buf.ninth == $past(dt_f))
		else $error("ninth bit not latched with word");
	a_slave_single_word_receive_enable: assert property (
		(state == usr_pkg::USR_IDLE && !master && !continuous_receive_enable && !tx_load)
		|=> state == usr_pkg::USR_IDLE)
		else $error("slave started reception without continuous enable");
	a_clock_idle: assert property (
		O_CLOCK_PIN_OE |-> $past(state == usr_pkg::USR_SHIFT && master))
		else $error("shift clock driven outside a word");
	a_write_resp: assert property (wr_go |=> O_BVALID [*1] ##1 1)
		else $error("write not answered");

	c_master_rx: cover property (rx_done && master);
	c_slave_rx: cover property (rx_done && !master && I_SLEEP);
	c_tx_second: cover property (tx_load ##[1:400] tx_load);
	c_overrun: cover property (rx_done && receive_int_flag);

endmodule

// >>> hdl/usr_pkg.sv
// register map, field positions, reset values and enums for the
// clocked serial port; shared by the design and the bench
package usr_pkg;

	// ====================================================================
	// register byte offsets on the bus
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFF_INTERRUPT_CONTROL_CORE = 6'h00;
	localparam logic [5:0] OFF_PERIPHERAL_FLAGS_ONE = 6'h04;
	localparam logic [5:0] OFF_PERIPHERAL_ENABLES_ONE = 6'h08;
	localparam logic [5:0] OFF_PERIPHERAL_PRIORITY_ONE = 6'h0C;
	localparam logic [5:0] OFF_RECEIVE_STATUS_CONTROL = 6'h10;
	localparam logic [5:0] OFF_RECEIVE_DATA_BUFFER = 6'h14;
	localparam logic [5:0] OFF_TRANSMIT_STATUS_CONTROL = 6'h18;
	localparam logic [5:0] OFF_BAUD_DIVISOR = 6'h1C;
	localparam logic [5:0] OFF_TRANSMIT_DATA_BUFFER = 6'h20;

	// ====================================================================
	// field positions
	localparam int B_GIE = 7;
	localparam int B_PERIPHERAL_INT_ENABLE = 6;
	localparam int B_RECEIVE_INT_FLAG = 5;
	localparam int B_TRANSMIT_INT_FLAG = 4;
	localparam int B_SERIAL_PORT_ENABLE = 7;
	localparam int B_RX9 = 6;
	localparam int B_SINGLE_WORD_RECEIVE_ENABLE = 5;
	localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
	localparam int B_ADDEN = 3;
	localparam int B_CLOCK_SOURCE_SELECT = 7;
	localparam int B_TX9 = 6;
	localparam int B_TRANSMIT_ENABLE_BIT = 5;
	localparam int B_SYNC = 4;
	localparam int B_BRGH = 2;
	localparam int B_TRANSMIT_NINTH_DATA = 0;

	// ====================================================================
	// reset values and bus answers
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_PERIPHERAL_PRIORITY_ONE = 8'hFF;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [3:0] NBITS8 = 4'h8;
	localparam logic [3:0] NBITS9 = 4'h9;

	// ====================================================================
	// types
	typedef enum logic {USR_IDLE, USR_SHIFT} usr_state_e;

	typedef struct packed {
		logic ninth;
		logic [7:0] data;
	} usr_word_s;

endpackage

// >>> tb/usr_peer.sv
// behavioural far-side peer of the clocked serial port
// assumes the bench resolves the shared clock and data lines from enables
`timescale 1ns/1ps
module usr_peer (
	input wire logic i_clk_line, // resolved shift clock line
	input wire logic i_data_line, // resolved data line
	output logic o_clk, // peer shift clock drive
	output logic o_data, // peer data drive
	output logic o_data_oe // peer drives data
);
	// ====================================================================
	// idle: clock parked low, data released
	initial begin
		o_clk = 1'b0;
		o_data = 1'b1;
		o_data_oe = 1'b0;
	end

	// ====================================================================
	// device masters the clock; new bit on each rise, settled before fall
	task automatic master_feed(input logic [8:0] w, input int n);
		o_data_oe = 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk_line);
			o_data = w[i]; // lsb first
		end
		@(negedge i_clk_line);
		o_data_oe = 1'b0;
		o_data = ~o_data; // released line must not keep the last bit
	endtask

	// ====================================================================
	// peer supplies a 64 ns clock only within the frame; samples mid-high
	task automatic slave_xfer(input logic [8:0] w, input int n,
		input bit drv, output logic [8:0] rx);
		rx = 9'h000;
		o_data_oe = drv;
		for (int i = 0; i < n; i++) begin
			o_clk = 1'b1;
			if (drv) begin
				o_data = w[i];
			end
			#16;
			rx[i] = i_data_line;
			#16;
			o_clk = 1'b0;
			#32;
		end
		o_data_oe = 1'b0;
		o_data = ~o_data; // release, no stale level
	endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench of the clocked serial port over its register bus
// assumes usr_pkg and usr_top are compiled first
`timescale 1ns/1ps
module testbench;
	logic ref_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
	logic sleep, awready, wready, bvalid, arready, rvalid, int_o, wake;
	logic [5:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic dut_clk, dut_clk_oe, dut_data, dut_data_oe;
	logic peer_clk, peer_data, peer_oe, clk_line, data_line;
	logic [8:0] rxw;
	int error_cnt, comparisons;
	logic [5:0] rst_addr [8] = '{usr_pkg::OFF_INTERRUPT_CONTROL_CORE, usr_pkg::OFF_PERIPHERAL_FLAGS_ONE,
		usr_pkg::OFF_PERIPHERAL_ENABLES_ONE, usr_pkg::OFF_PERIPHERAL_PRIORITY_ONE, usr_pkg::OFF_RECEIVE_STATUS_CONTROL,
		usr_pkg::OFF_RECEIVE_DATA_BUFFER, usr_pkg::OFF_TRANSMIT_STATUS_CONTROL, usr_pkg::OFF_BAUD_DIVISOR};
	logic [7:0] rst_val [8] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00,
		8'h02, 8'h00};

	// ====================================================================
	// shared lines: whoever enables drives
	assign clk_line = dut_clk_oe ? dut_clk : peer_clk;
	// nobody driving: line shows the inverse, never a stale bit
	assign data_line = dut_data_oe ? dut_data
		: (peer_oe ? peer_data : ~dut_data);

	always #2.5 ref_clk = ~ref_clk;

	usr_top i_dut (.I_REF_CLK(ref_clk), .I_SYS_RST(sys_rst),
		.I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
		.I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
		.O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
		.O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp),
		.O_RVALID(rvalid), .I_RREADY(rready), .I_CLOCK_PIN(clk_line),
		.O_CLOCK_PIN(dut_clk), .O_CLOCK_PIN_OE(dut_clk_oe),
		.I_DATA_PIN(data_line), .O_DATA_PIN(dut_data),
		.O_DATA_PIN_OE(dut_data_oe), .I_SLEEP(sleep), .O_INT(int_o),
		.O_WAKE(wake));

	usr_peer i_peer (.i_clk_line(clk_line), .i_data_line(data_line),
		.o_clk(peer_clk), .o_data(peer_data), .o_data_oe(peer_oe));

	// ====================================================================
	// comparison and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic final_report;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ====================================================================
	// bus master: each channel held until its own ready is sampled
	task automatic axi_write(input logic [5:0] a, input logic [7:0] d,
		output logic [1:0] r);
		bit ad;
		bit wd;
		@(posedge ref_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h00_0000, d};
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ad = 0;
		wd = 0;
		while (!(ad && wd)) begin
			@(posedge ref_clk);
			if (!ad && awready) begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [5:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge ref_clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge ref_clk); while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [1:0] r;
		axi_write(a, d, r);
		check(32'(r), 32'(usr_pkg::RESP_OKAY));
	endtask

	task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
		axi_read(a, rd, rs);
		check(32'(rs), 32'(usr_pkg::RESP_OKAY));
		check(rd, {24'h00_0000, e});
	endtask

	// reads until all masked flag bits are set, at most 200 tries
	task automatic poll(input logic [5:0] a, input logic [7:0] m);
		for (int i = 0; i < 200; i++) begin
			axi_read(a, rd, rs);
			if ((rd[7:0] & m) == m) begin
				break;
			end
		end
		check(32'(rd[7:0] & m), 32'(m));
	endtask

	// ====================================================================
	// watchdog: whole run needs about a thousand cycles
	initial begin
		repeat (40000) @(posedge ref_clk);
		error_cnt++;
		final_report;
	end

	// ====================================================================
	// main sequence
	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, sleep} = 6'h00;
		awaddr = 6'h00;
		araddr = 6'h00;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		error_cnt = 0;
		comparisons = 0;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		// reset values, then unmapped places answer with an error
		for (int i = 0; i < 8; i++) begin
			rd_chk(rst_addr[i], rst_val[i]);
		end
		axi_read(6'h24, rd, rs);
		check(32'(rs), 32'(usr_pkg::RESP_SLVERR));
		check(rd, usr_pkg::RD_ZERO);
		axi_write(6'h3C, 8'h5A, rs);
		check(32'(rs), 32'(usr_pkg::RESP_SLVERR));
		// master single-word reception, interrupt gating
		wr(usr_pkg::OFF_BAUD_DIVISOR, 8'h07);
		wr(usr_pkg::OFF_TRANSMIT_STATUS_CONTROL, 8'h90);
		wr(usr_pkg::OFF_PERIPHERAL_ENABLES_ONE, 8'h20);
		rd_chk(usr_pkg::OFF_RECEIVE_STATUS_CONTROL, 8'h00);
		fork
			i_peer.master_feed(9'h0A5, 8);
		join_none
		wr(usr_pkg::OFF_RECEIVE_STATUS_CONTROL, 8'hA0);
		poll(usr_pkg::OFF_PERIPHERAL_FLAGS_ONE, 8'h20);
		rd_chk(usr_pkg::OFF_RECEIVE_STATUS_CONTROL, 8'h80);
		check(32'(dut_clk_oe), 32'h0000_0000);
		check(32'(int_o), 32'h0000_0000);
		wr(usr_pkg::OFF_INTERRUPT_CONTROL_CORE, 8'h40);
		repeat (2) @(posedge ref_clk);
		check(32'(int_o), 32'h0000_0000);
		wr(usr_pkg::OFF_INTERRUPT_CONTROL_CORE, 8'hC0);
		repeat (2) @(posedge ref_clk);
		check(32'(int_o), 32'h0000_0001);
		rd_chk(usr_pkg::OFF_RECEIVE_DATA_BUFFER, 8'hA5);
		rd_chk(usr_pkg::OFF_PERIPHERAL_FLAGS_ONE, 8'h00);
		// slave continuous 9-bit reception, first word during sleep, both enables set
		wr(usr_pkg::OFF_TRANSMIT_STATUS_CONTROL, 8'h10);
		wr(usr_pkg::OFF_RECEIVE_STATUS_CONTROL, 8'hF0);
		@(posedge ref_clk);
		sleep <= 1'b1;
		i_peer.slave_xfer(9'h13C, 9, 1'b1, rxw);
		repeat (4) @(posedge ref_clk);
		check(32'(wake), 32'h0000_0001);
		sleep <= 1'b0;
		rd_chk(usr_pkg::OFF_RECEIVE_STATUS_CONTROL, 8'hF1);
		rd_chk(usr_pkg::OFF_RECEIVE_DATA_BUFFER, 8'h3C);
		i_peer.slave_xfer(9'h0C3, 9, 1'b1, rxw);
		poll(usr_pkg::OFF_PERIPHERAL_FLAGS_ONE, 8'h20);
		rd_chk(usr_pkg::OFF_RECEIVE_STATUS_CONTROL, 8'hF0);
		rd_chk(usr_pkg::OFF_RECEIVE_DATA_BUFFER, 8'hC3);
		// overrun: second word dropped while flag set, cleared with enable
		i_peer.slave_xfer(9'h1AA, 9, 1'b1, rxw);
		i_peer.slave_xfer(9'h055, 9, 1'b1, rxw);
		poll(usr_pkg::OFF_PERIPHERAL_FLAGS_ONE, 8'h20);
		rd_chk(usr_pkg::OFF_RECEIVE_STATUS_CONTROL, 8'hF3);
		rd_chk(usr_pkg::OFF_RECEIVE_DATA_BUFFER, 8'hAA);
		wr(usr_pkg::OFF_RECEIVE_STATUS_CONTROL, 8'h80);
		axi_read(usr_pkg::OFF_RECEIVE_STATUS_CONTROL, rd, rs);
		check(rd & 32'h0000_0002, 32'h0000_0000);
		// slave transmit of two 9-bit words across sleep
		wr(usr_pkg::OFF_TRANSMIT_STATUS_CONTROL, 8'h70);
		wr(usr_pkg::OFF_TRANSMIT_STATUS_CONTROL, 8'h71);
		wr(usr_pkg::OFF_PERIPHERAL_ENABLES_ONE, 8'h10);
		wr(usr_pkg::OFF_TRANSMIT_DATA_BUFFER, 8'h5A);
		wr(usr_pkg::OFF_TRANSMIT_DATA_BUFFER, 8'h96);
		check(32'(dut_data_oe), 32'h0000_0001);
		rd_chk(usr_pkg::OFF_PERIPHERAL_FLAGS_ONE, 8'h00);
		@(posedge ref_clk);
		sleep <= 1'b1;
		i_peer.slave_xfer(9'h000, 9, 1'b0, rxw);
		check(32'(rxw), 32'h0000_015A);
		rd_chk(usr_pkg::OFF_PERIPHERAL_FLAGS_ONE, 8'h10);
		check(32'(wake), 32'h0000_0001);
		sleep <= 1'b0;
		i_peer.slave_xfer(9'h000, 9, 1'b0, rxw);
		check(32'(rxw), 32'h0000_0196);
		final_report;
	end
endmodule
